// ===== rtl/sll_pkg.sv
// constants for the serial latch loader
package sll_pkg;
    localparam int unsigned WORD_BITS   = 24;
    localparam int unsigned SEL_LSB     = 0;
    localparam int unsigned SEL_MSB     = 1;
    localparam logic [1:0]  SEL_REF     = 2'h0;
    localparam logic [1:0]  SEL_MAIN    = 2'h1;
    localparam logic [1:0]  SEL_FUNC    = 2'h2;
    localparam logic [1:0]  SEL_INIT    = 2'h3;
    localparam logic [23:0] LATCH_RST   = 24'h00_0000;
    localparam logic [2:0]  DONE_NONE   = 3'h0;
    localparam int unsigned DONE_REF    = 0;
    localparam int unsigned DONE_MAIN   = 1;
    localparam int unsigned DONE_INIT   = 2;
    localparam logic [2:0]  DONE_ALL    = 3'h7;
endpackage : sll_pkg

// ===== rtl/sll_serial_latch_loader.sv
// serial word shifter and three-latch commit logic (init writes the function latch)
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// R1: each serial clock rising edge shifts data input into 24-bit register.
// R2: strobe rising edge copies shift register into the addressed latch.
// R3: host keeps serial clock at or below 20 MHz.
// R4: host drives strobe low before first bit of a word.
// R5: host sends complete 24-bit words, possibly as three bytes.
// R6: host raises strobe after the last bit of the third byte.
// R7: host uses clock phase zero, data stable at rising edge.
// R8: output stays inactive until reference, main and init latches written.
// R9: chip enable input controls power-down.
// R10: monitor output presents lock indication when lock detect selected.
// R11: two low bits select reference, main, function or init latch.
// R12: init write loads function settings and issues internal reset pulse.
// R13: first main write after init repeats pulse, later ones do not.
// R14: chip enable low powers down at once, latches kept.
// R15: words shift msb first, select bits arrive last.
// R16: with strobe low, latches never change.
module sll_serial_latch_loader (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // serial link pins
    input  wire logic        serial_clk_i,
    input  wire logic        serial_word_input_i,
    input  wire logic        word_commit_strobe_i,
    input  wire logic        chip_enable_i,
    // lock monitor
    input  wire logic        lock_indication_i,
    input  wire logic        lock_detect_sel_i,
    // latch contents and status
    output logic [23:0]      ref_latch_o,
    output logic [23:0]      main_latch_o,
    output logic [23:0]      func_latch_o,
    output logic             counter_reset_pulse_o,
    output logic             power_down_o,
    output logic             output_active_o,
    output logic             monitor_output_pin_o
);
    // two-stage synchronisers; chip enable stays raw so power-down is immediate
    logic [3:0] sync1_reg,     sync1_next;
    logic [3:0] sync2_reg,     sync2_next;
    logic [3:0] sync_prev_reg, sync_prev_next;
    logic       sclk_rise;
    logic       strobe_rise;

    logic [23:0] shift_reg,  shift_next;
    logic [23:0] ref_reg,    ref_next;
    logic [23:0] main_reg,   main_next;
    logic [23:0] func_reg,   func_next;
    logic [2:0]  done_reg,   done_next;
    logic        arm_reg,    arm_next;
    logic        pulse_reg,  pulse_next;
    logic        mon_reg,    mon_next;

    always_comb begin
        sync1_next     = {lock_indication_i, word_commit_strobe_i, serial_word_input_i, serial_clk_i};
        sync2_next     = sync1_reg;
        sync_prev_next = sync2_reg;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_reg     <= 4'h0;
            sync2_reg     <= 4'h0;
            sync_prev_reg <= 4'h0;
        end else begin
            sync1_reg     <= sync1_next;
            sync2_reg     <= sync2_next;
            sync_prev_reg <= sync_prev_next;
        end
    end

    assign sclk_rise   = sync2_reg[0] & ~sync_prev_reg[0];
    assign strobe_rise = sync2_reg[2] & ~sync_prev_reg[2];

    always_comb begin
        shift_next = shift_reg;
        ref_next   = ref_reg;
        main_next  = main_reg;
        func_next  = func_reg;
        done_next  = done_reg;
        arm_next   = arm_reg;
        // pulse defaults low so it lasts exactly one cycle
        pulse_next = 1'b0;
        // data sampled from sync_prev_reg, one stage behind the clock edge, so phase-zero timing holds
        if (sclk_rise) begin
            shift_next = {shift_reg[22:0], sync_prev_reg[1]}; // R1 R15 R7
        end
        // latches only move on the strobe edge
        if (strobe_rise) begin // R2 R16
            unique case (shift_reg[sll_pkg::SEL_MSB:sll_pkg::SEL_LSB]) // R11
                sll_pkg::SEL_REF: begin
                    ref_next = shift_reg;
                    done_next[sll_pkg::DONE_REF] = 1'b1; // R8
                end
                sll_pkg::SEL_MAIN: begin
                    main_next = shift_reg;
                    done_next[sll_pkg::DONE_MAIN] = 1'b1;
                    if (arm_reg) begin
                        pulse_next = 1'b1; // R13
                        arm_next   = 1'b0;
                    end
                end
                sll_pkg::SEL_FUNC: begin
                    // plain function write leaves counters and arm alone
                    func_next = shift_reg;
                end
                sll_pkg::SEL_INIT: begin
                    func_next  = shift_reg; // R12
                    pulse_next = 1'b1;
                    arm_next   = 1'b1;
                    done_next[sll_pkg::DONE_INIT] = 1'b1;
                end
            endcase
        end
        // lock level is slow, a three-cycle lag is harmless
        mon_next = lock_detect_sel_i & sync2_reg[3]; // R10
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg <= sll_pkg::LATCH_RST;
            ref_reg   <= sll_pkg::LATCH_RST;
            main_reg  <= sll_pkg::LATCH_RST;
            func_reg  <= sll_pkg::LATCH_RST;
            done_reg  <= sll_pkg::DONE_NONE;
            arm_reg   <= 1'b0;
            pulse_reg <= 1'b0;
            mon_reg   <= 1'b0;
        end else begin
            shift_reg <= shift_next;
            ref_reg   <= ref_next;
            main_reg  <= main_next;
            func_reg  <= func_next;
            done_reg  <= done_next;
            arm_reg   <= arm_next;
            pulse_reg <= pulse_next;
            mon_reg   <= mon_next;
        end
    end

    assign ref_latch_o           = ref_reg;
    assign main_latch_o          = main_reg;
    assign func_latch_o          = func_reg;
    assign counter_reset_pulse_o = pulse_reg;
    // power-down follows the pin combinationally; latches are untouched
    assign power_down_o          = ~chip_enable_i; // R9 R14
    assign output_active_o       = (done_reg == sll_pkg::DONE_ALL) & chip_enable_i; // R8
    assign monitor_output_pin_o  = mon_reg;

    AST_SHIFT_IN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
        sclk_rise |=> shift_reg == {$past(shift_reg[22:0]), $past(sync_prev_reg[1])})
        else $error("shift register did not take data bit");
    AST_NO_COMMIT_LOW: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R16
        !strobe_rise |=> $stable(ref_reg) && $stable(main_reg) && $stable(func_reg))
        else $error("latch changed without strobe edge");
    AST_REF_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R2
        strobe_rise && shift_reg[1:0] == sll_pkg::SEL_REF |=> ref_reg == $past(shift_reg))
        else $error("reference latch not loaded");
    AST_MAIN_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R11
        strobe_rise && shift_reg[1:0] == sll_pkg::SEL_MAIN |=> main_reg == $past(shift_reg) && $stable(ref_reg))
        else $error("main latch not loaded");
    AST_INIT_PULSE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
        strobe_rise && shift_reg[1:0] == sll_pkg::SEL_INIT |=> pulse_reg && func_reg == $past(shift_reg) ##1 !pulse_reg)
        else $error("init write lacked pulse or function load");
    AST_MAIN_REPEAT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
        strobe_rise && shift_reg[1:0] == sll_pkg::SEL_MAIN |=> pulse_reg == $past(arm_reg) && !arm_reg)
        else $error("main write pulse wrong");
    AST_ACTIVE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R8
        output_active_o |-> done_reg[0] && done_reg[1] && done_reg[2] && chip_enable_i)
        else $error("output active before three writes");
    AST_POWER_DOWN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R14
        !chip_enable_i |-> power_down_o && !output_active_o)
        else $error("chip enable low did not power down");
    AST_MONITOR: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R10
        ##1 monitor_output_pin_o == ($past(lock_detect_sel_i) && $past(sync2_reg[3])))
        else $error("monitor output mismatch");

    // further guards: holds without edges, per-select loads and holds, arm, pulse, done record, monitor and power-down
    AST_SHIFT_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R1
        !sclk_rise |=> $stable(shift_reg))
        else $error("shift register moved without serial clock edge");
    AST_FUNC_LOAD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R11
        strobe_rise && shift_reg[1:0] == sll_pkg::SEL_FUNC |=> func_reg == $past(shift_reg) && !pulse_reg)
        else $error("function latch not loaded or pulsed");
    AST_REF_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R11
        strobe_rise && shift_reg[1:0] != sll_pkg::SEL_REF |=> $stable(ref_reg))
        else $error("reference latch written by other select");
    AST_MAIN_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R11
        strobe_rise && shift_reg[1:0] != sll_pkg::SEL_MAIN |=> $stable(main_reg))
        else $error("main latch written by other select");
    AST_FUNC_ONLY: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R11
        strobe_rise && !shift_reg[1] |=> $stable(func_reg))
        else $error("function latch written by counter select");
    AST_INIT_ARM: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
        strobe_rise && shift_reg[1:0] == sll_pkg::SEL_INIT |=> arm_reg)
        else $error("init write did not arm main pulse");
    AST_ARM_KEEP: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R13
        strobe_rise && !shift_reg[0] |=> $stable(arm_reg))
        else $error("arm changed on reference or function write");
    AST_PULSE_COMMIT: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
        !strobe_rise |=> !pulse_reg)
        else $error("reset pulse without commit");
    AST_PULSE_ONE: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R12
        pulse_reg |=> !pulse_reg)
        else $error("reset pulse longer than one cycle");
    AST_DONE_HOLD: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R8
        1'b1 |=> (done_reg & $past(done_reg)) == $past(done_reg))
        else $error("written-latch record lost a bit");
    AST_DONE_REF: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R8
        strobe_rise && shift_reg[1:0] == sll_pkg::SEL_REF |=> done_reg[sll_pkg::DONE_REF])
        else $error("reference write not recorded");
    AST_ACTIVE_ON: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R8
        done_reg == sll_pkg::DONE_ALL && chip_enable_i |-> output_active_o)
        else $error("output inactive after three writes");
    AST_MON_OFF: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R10
        !lock_detect_sel_i |=> !monitor_output_pin_o)
        else $error("monitor active without lock detect select");
    AST_PD_RUN: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i) // R9
        chip_enable_i |-> !power_down_o)
        else $error("power-down while chip enable high");

endmodule : sll_serial_latch_loader
`default_nettype wire

// ===== verification/sll_host_model.sv
// serial master model that writes words into the latch loader
`timescale 1ns/1ps
`default_nettype none
module sll_host_model (
    // serial link pins
    output logic sclk_o,
    output logic word_bit_o,
    output logic strobe_o
);
    initial begin
        sclk_o     = 1'b0;
        word_bit_o = 1'b0;
        strobe_o   = 1'b0;
    end
    // 200 ns clock period; clock rests low between words
    task automatic send_word(input logic [23:0] w, input bit commit);
        strobe_o = 1'b0;
        #100;
        for (int i = 23; i >= 0; i--) begin
            word_bit_o = w[i];
            #100;
            sclk_o = 1'b1;
            #100;
            sclk_o = 1'b0;
        end
        // stale level would hide a late sample
        word_bit_o = ~w[0];
        #100;
        if (commit) strobe_o = 1'b1;
        #100;
    endtask : send_word
endmodule : sll_host_model
`default_nettype wire

// ===== verification/serial_latch_loader_tb.sv
// self-checking bench for the serial latch loader
`timescale 1ns/1ps
`default_nettype none
module serial_latch_loader_tb;
    logic        sys_clk_i = 1'b0, rst_n_i = 1'b0, chip_enable_i = 1'b1;
    logic        lock_indication_i = 1'b0, lock_detect_sel_i = 1'b0;
    wire         sclk, word_bit, strobe;
    logic [23:0] ref_latch_o, main_latch_o, func_latch_o, e_ref = '0, e_main = '0, e_func = '0;
    logic        counter_reset_pulse_o, power_down_o, output_active_o, monitor_output_pin_o;
    int          miscompares = 0, tests_run = 0, pulses = 0, e_pulses = 0, seed = 36;
    bit          arm = 1'b0;
    always #12.5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (counter_reset_pulse_o === 1'b1) pulses++;
    sll_host_model host_u (.sclk_o(sclk), .word_bit_o(word_bit), .strobe_o(strobe));
    sll_serial_latch_loader dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .serial_clk_i(sclk),
        .serial_word_input_i(word_bit), .word_commit_strobe_i(strobe), .chip_enable_i(chip_enable_i),
        .lock_indication_i(lock_indication_i), .lock_detect_sel_i(lock_detect_sel_i),
        .ref_latch_o(ref_latch_o), .main_latch_o(main_latch_o), .func_latch_o(func_latch_o),
        .counter_reset_pulse_o(counter_reset_pulse_o), .power_down_o(power_down_o),
        .output_active_o(output_active_o), .monitor_output_pin_o(monitor_output_pin_o));
    task automatic finish_test();
        if (miscompares == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic check_all();
        check("ref_latch", ref_latch_o, e_ref);
        check("main_latch", main_latch_o, e_main);
        check("func_latch", func_latch_o, e_func);
        check("pulse_count", 24'(pulses), 24'(e_pulses));
    endtask : check_all
    task automatic word(input logic [23:0] w);
        host_u.send_word(w, 1'b1);
        repeat (8) @(negedge sys_clk_i);
        case (w[1:0])
            sll_pkg::SEL_REF: e_ref = w;
            sll_pkg::SEL_MAIN: begin
                e_main = w;
                if (arm) e_pulses++;
                arm = 1'b0;
            end
            default: begin
                e_func = w;
                if (w[1:0] == sll_pkg::SEL_INIT) begin
                    e_pulses++;
                    arm = 1'b1;
                end
            end
        endcase
        check_all();
    endtask : word
    task automatic rand_word(input logic [1:0] sel);
        logic [23:0] w;
        w = 24'($random(seed));
        w[1:0] = sel;
        word(w);
    endtask : rand_word
    initial begin
        #1ms;
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (3) @(negedge sys_clk_i);
        rst_n_i = 1'b1;
        rand_word(sll_pkg::SEL_INIT);
        rand_word(sll_pkg::SEL_REF);
        check("active", 24'(output_active_o), 24'h00_0000);
        rand_word(sll_pkg::SEL_MAIN);
        check("active", 24'(output_active_o), 24'h00_0001);
        rand_word(sll_pkg::SEL_MAIN);
        word(24'hFF_FFFE);
        word(24'h00_0000);
        // bits shifted without a commit must not land anywhere
        host_u.send_word(24'hAA_AAA9, 1'b0);
        repeat (8) @(negedge sys_clk_i);
        check_all();
        for (int n = 0; n < 12; n++) rand_word(2'($random(seed)));
        chip_enable_i = 1'b0;
        #1;
        check("power_down", 24'(power_down_o), 24'h00_0001);
        check("active_pd", 24'(output_active_o), 24'h00_0000);
        check_all();
        @(negedge sys_clk_i);
        chip_enable_i = 1'b1;
        #1;
        check("active_back", 24'(output_active_o), 24'h00_0001);
        for (int k = 0; k < 4; k++) begin
            @(negedge sys_clk_i);
            {lock_detect_sel_i, lock_indication_i} = 2'(k);
            repeat (6) @(negedge sys_clk_i);
            check("monitor", 24'(monitor_output_pin_o), 24'(k == 3));
        end
        finish_test();
    end
endmodule : serial_latch_loader_tb
`default_nettype wire
